// ===== common/ifeb_chan_if.sv
`timescale 1ns/10ps
interface ifeb_chan_if;
    logic mode;
    logic pol;
    logic sw_clear;
    logic ctl_en;
    logic flag;

    // Register bank side
    modport ctrl
    (
        output mode,
        output pol,
        output sw_clear,
        output ctl_en,
        input  flag
    );

    // Port channel side
    modport chan
    (
        input  mode,
        input  pol,
        input  sw_clear,
        input  ctl_en,
        output flag
    );
endinterface

// ===== common/ifeb_pkg.sv
package ifeb_pkg;

    // Bus and register geometry
    localparam int          DW          = 16;
    localparam int          AW          = 16;
    localparam logic [15:0] FLAG_OFS    = 16'h4300;
    localparam logic [15:0] ENA_OFS     = 16'h4302;
    localparam logic [15:0] CTL_OFS     = 16'h4304;
    localparam logic [15:0] PSET_OFS    = 16'h4306;
    localparam logic [15:0] ISET_OFS    = 16'h4310;
    localparam logic [15:0] CLR_OFS     = 16'h4314;
    localparam logic [15:0] REG_STEP    = 16'h0002;
    localparam int          PSET_REGS   = 4;
    localparam int          ISET_REGS   = 2;

    // Source layout
    localparam int          NSRC        = 16;
    localparam int          NPORT       = 8;
    localparam int          NINT        = 7;
    localparam int          LVL_W       = 3;
    localparam int          VEC_W       = 4;
    localparam int          NIB         = 4;
    localparam int          RSV_BIT     = 13;
    localparam int          RSV_INT_IDX = 5;
    localparam logic [15:0] INT_MASK    = 16'hdf00;
    localparam logic [15:0] ENA_MASK    = 16'hdfff;

    // Control register field
    localparam int          CTL_EN_BIT  = 0;

    // Port setup fields, two ports per register
    localparam int          P0_LVL_LSB  = 0;
    localparam int          P0_MODE_BIT = 4;
    localparam int          P0_POL_BIT  = 5;
    localparam int          P1_LVL_LSB  = 8;
    localparam int          P1_MODE_BIT = 12;
    localparam int          P1_POL_BIT  = 13;

    // Reset values
    localparam logic [15:0] FLAG_RST    = 16'h0000;
    localparam logic [15:0] ENA_RST     = 16'h0000;
    localparam logic        CTL_RST     = 1'b0;
    localparam logic [2:0]  LVL_RST     = 3'h0;
    localparam logic        MODE_PULSE  = 1'b0;
    localparam logic        MODE_LEVEL  = 1'b1;
    localparam logic        POL_NEG     = 1'b0;
    localparam logic        POL_POS     = 1'b1;
    localparam logic        PIN_IDLE    = 1'b1;
    localparam int          SYNC_STAGES = 3;

endpackage

// ===== hdl/ifeb_port_chan.sv
`timescale 1ns/10ps
module ifeb_port_chan
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Port pin, asynchronous to the clock
    input  wire logic pin_in,
    // Setup and flag toward the register bank
    ifeb_chan_if.chan ch
);
    import ifeb_pkg::*;

    logic [SYNC_STAGES-1:0] sync_q;
    logic                   filt_q;
    logic                   prev_q;
    logic                   flag_q;
    logic                   active;
    logic                   pulse_seen;

    // Three stage synchroniser; the first stage feeds only the second
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            sync_q <= {SYNC_STAGES{PIN_IDLE}};
        else
            sync_q <= {sync_q[SYNC_STAGES-2:0], pin_in};
    end

    // A change counts only once the last two stages agree
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            filt_q <= PIN_IDLE;
            prev_q <= PIN_IDLE;
        end
        else
        begin
            if (sync_q[1] == sync_q[2])
                filt_q <= sync_q[2];
            prev_q <= filt_q;
        end
    end

    // Polarity picks the active sense and the pulse direction
    assign active     = (filt_q == ch.pol);
    assign pulse_seen = active && (prev_q != ch.pol);

    // Flag: level mode follows the pin, pulse mode latches and stops sampling
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            flag_q <= 1'b0;
        else if (ch.mode == MODE_LEVEL)
            flag_q <= ch.ctl_en && active;
        else if (ch.ctl_en && pulse_seen && !flag_q)
            flag_q <= 1'b1;
        else if (ch.sw_clear)
            flag_q <= 1'b0;
    end

    assign ch.flag = flag_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_level_steady;
        (ch.mode == MODE_LEVEL && ch.ctl_en && pin_in == ch.pol)[*5];
    endsequence

    a_pulse_flag_hold: assert property (
        ch.mode == MODE_PULSE && flag_q && !ch.sw_clear |=> flag_q)
        else $error("pulse flag dropped without a clear");

    a_level_pin_follow: assert property (
        s_level_steady |-> ##[1:2] flag_q)
        else $error("level flag did not follow active pin");
endmodule

// ===== hdl/ifeb_prio_sel.sv
`timescale 1ns/10ps
module ifeb_prio_sel
#(
    parameter int N  = ifeb_pkg::NSRC,
    parameter int LW = ifeb_pkg::LVL_W
)
(
    // Pending sources and their levels
    input  wire logic [N-1:0]         pending,
    input  wire logic [N*LW-1:0]      levels,
    // Winning source
    output logic                      valid,
    output logic [LW-1:0]             level,
    output logic [$clog2(N)-1:0]      index
);
    import ifeb_pkg::*;

    if (N < 2 || LW < 1)
    begin : g_chk
        $error("ifeb_prio_sel needs at least two sources and a level width");
    end

    // Highest level wins; strict compare keeps the lowest index on a tie
    always_comb
    begin
        valid = 1'b0;
        level = '0;
        index = '0;
        for (int i = 0; i < N; i++)
        begin
            if (pending[i] && (!valid || levels[i*LW +: LW] > level))
            begin
                valid = 1'b1;
                level = levels[i*LW +: LW];
                index = ($clog2(N))'(i);
            end
        end
    end
endmodule

// ===== hdl/ifeb_top.sv
// Summary of operation
// - An internal flag reads 1 after its cause, writing 1 clears it, 0 does nothing, reset 0.
// - An internal cause sets its flag only while the controller enable bit is 1.
// - A request goes out only if enabled, highest priority, core enabled and level above core.
// - A cause sets its flag whatever the source enable and level settings are.
// - Bit 15 is the two-wire master, bit 14 serial channel 0, bit 12 the serial port.
// - Bits 11 to 8 each latch the underflow of one of four timers.
// - Bits 7 to 0 latch port inputs 7 to 0 on an edge or level trigger.
// - Port flag writes are ignored except the clear of pulse mode.
// - Enable bits are read and write, 1 permits and 0 blocks, reset 0.
// - Enable bit positions match the flag bit positions.
// - Pulse mode samples each clock, sets the flag and stops sampling until cleared.
// - Level mode makes the port flag follow the input and writes cannot clear it.
// - A polarity bit picks rising or high when 1, falling or low when 0 by default.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module ifeb_top
(
    // Clock and reset
    input  wire logic                           core_clk,
    input  wire logic                           reset_n,
    // Register port
    input  wire logic [ifeb_pkg::AW-1:0]        reg_addr,
    input  wire logic [ifeb_pkg::DW-1:0]        reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [ifeb_pkg::DW-1:0]        reg_rdata,
    // Interrupt causes
    input  wire logic [ifeb_pkg::NINT-1:0]      internal_cause,
    input  wire logic [ifeb_pkg::NPORT-1:0]     port_in,
    // Processor core side
    input  wire logic                           core_interrupt_enable,
    input  wire logic [ifeb_pkg::LVL_W-1:0]     core_interrupt_level,
    output logic                                int_req,
    output logic      [ifeb_pkg::LVL_W-1:0]     int_level,
    output logic      [ifeb_pkg::VEC_W-1:0]     int_vector,
    // Any enabled flag set
    output logic                                irq
);
    import ifeb_pkg::*;

    logic [15:8]           iflag_q;
    logic [NSRC-1:0]       ena_q;
    logic                  ctl_q;
    logic [LVL_W-1:0]      plev_q [NPORT];
    logic [NPORT-1:0]      pmode_q;
    logic [NPORT-1:0]      ppol_q;
    logic [LVL_W-1:0]      ilv_q [8];
    logic [DW-1:0]         rdata_q;
    logic                  req_q;
    logic [LVL_W-1:0]      lvl_q;
    logic [VEC_W-1:0]      vec_q;

    logic                  wr_flag;
    logic                  wr_ena;
    logic                  wr_ctl;
    logic                  wr_clr;
    logic [15:8]           icause;
    logic [15:8]           iclr;
    logic [NPORT-1:0]      port_flag;
    logic [NSRC-1:0]       flags_all;
    logic [NSRC-1:0]       pending;
    logic [NSRC*LVL_W-1:0] lvl_bus;
    logic                  win_valid;
    logic [LVL_W-1:0]      win_level;
    logic [VEC_W-1:0]      win_index;
    logic                  req_d;
    logic [DW-1:0]         rd_d;

    // Address of the k-th setup register in a bank
    function automatic logic [AW-1:0] bank_addr(input logic [AW-1:0] base, input int k);
        bank_addr = base + (AW)'(k) * REG_STEP;
    endfunction

    // Write strobes for the fixed registers
    assign wr_flag = reg_wr && (reg_addr == FLAG_OFS);
    assign wr_ena  = reg_wr && (reg_addr == ENA_OFS);
    assign wr_ctl  = reg_wr && (reg_addr == CTL_OFS);
    assign wr_clr  = reg_wr && (reg_addr == CLR_OFS);

    // Peripheral causes placed on their flag positions, bit 13 unused
    assign icause = {internal_cause[6:5], 1'b0, internal_cause[4:0]};

    // Either the flag register or the clear alias clears with ones
    assign iclr = (wr_flag ? reg_wdata[15:8] : 8'h00)
                | (wr_clr ? reg_wdata[15:8] : 8'h00);

    // Internal flags; a cause in the clearing cycle wins so no event is lost
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            iflag_q <= FLAG_RST[15:8];
        else
            iflag_q <= ((iflag_q & ~iclr) | (icause & {8{ctl_q}}))
                       & INT_MASK[15:8];
    end

    // Source enables, bit 13 held at zero
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            ena_q <= ENA_RST;
        else if (wr_ena)
            ena_q <= reg_wdata & ENA_MASK;
    end

    // Controller enable gates every flag from being set
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctl_q <= CTL_RST;
        else if (wr_ctl)
            ctl_q <= reg_wdata[CTL_EN_BIT];
    end

    // Port level, trigger mode and polarity, two ports per register
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int p = 0; p < NPORT; p++)
                plev_q[p] <= LVL_RST;
            pmode_q <= {NPORT{MODE_PULSE}};
            ppol_q  <= {NPORT{POL_NEG}};
        end
        else
        begin
            for (int k = 0; k < PSET_REGS; k++)
            begin
                if (reg_wr && reg_addr == bank_addr(PSET_OFS, k))
                begin
                    plev_q[2*k]    <= reg_wdata[P0_LVL_LSB +: LVL_W];
                    pmode_q[2*k]   <= reg_wdata[P0_MODE_BIT];
                    ppol_q[2*k]    <= reg_wdata[P0_POL_BIT];
                    plev_q[2*k+1]  <= reg_wdata[P1_LVL_LSB +: LVL_W];
                    pmode_q[2*k+1] <= reg_wdata[P1_MODE_BIT];
                    ppol_q[2*k+1]  <= reg_wdata[P1_POL_BIT];
                end
            end
        end
    end

    // Internal source levels, one nibble each; the reserved slot stays zero
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int j = 0; j < 8; j++)
                ilv_q[j] <= LVL_RST;
        end
        else
        begin
            for (int j = 0; j < 8; j++)
            begin
                if (j != RSV_INT_IDX && reg_wr && reg_addr == bank_addr(ISET_OFS, j / NIB))
                    ilv_q[j] <= reg_wdata[(j % NIB)*NIB +: LVL_W];
            end
        end
    end

    // One synchronised trigger channel per port input
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        ifeb_chan_if pch ();

        // Clear reaches the channel, which honours it only in pulse mode
        assign pch.mode     = pmode_q[p];
        assign pch.pol      = ppol_q[p];
        assign pch.ctl_en   = ctl_q;
        assign pch.sw_clear = (wr_flag || wr_clr) && reg_wdata[p];
        assign port_flag[p] = pch.flag;

        ifeb_port_chan u_chan
        (
            .core_clk (core_clk),
            .reset_n  (reset_n),
            .pin_in   (port_in[p]),
            .ch       (pch)
        );
    end

    // Status view and the enabled subset
    assign flags_all = {iflag_q, port_flag};
    assign pending   = flags_all & ena_q;

    // Level bus: ports first, then internal sources
    always_comb
    begin
        lvl_bus = '0;
        for (int i = 0; i < NPORT; i++)
            lvl_bus[i*LVL_W +: LVL_W] = plev_q[i];
        for (int j = 0; j < 8; j++)
            lvl_bus[(NPORT+j)*LVL_W +: LVL_W] = ilv_q[j];
    end

    // Pick the pending source of highest priority
    ifeb_prio_sel #(
        .N  (NSRC),
        .LW (LVL_W)
    ) u_prio (
        .pending (pending),
        .levels  (lvl_bus),
        .valid   (win_valid),
        .level   (win_level),
        .index   (win_index)
    );

    // Core accepts only above its current level and with interrupts on
    assign req_d = win_valid && core_interrupt_enable
                && (win_level > core_interrupt_level);

    // Request, level and vector leave from flops; a new winner replaces the old one
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_q <= 1'b0;
            lvl_q <= LVL_RST;
            vec_q <= '0;
        end
        else
        begin
            req_q <= req_d;
            lvl_q <= win_level;
            vec_q <= win_index;
        end
    end

    // Read decode; unmapped and write-only addresses read zero
    always_comb
    begin
        rd_d = '0;
        if (reg_addr == FLAG_OFS)
            rd_d = flags_all & (INT_MASK | 16'h00ff);
        else if (reg_addr == ENA_OFS)
            rd_d = ena_q;
        else if (reg_addr == CTL_OFS)
            rd_d[CTL_EN_BIT] = ctl_q;
        for (int k = 0; k < PSET_REGS; k++)
        begin
            if (reg_addr == bank_addr(PSET_OFS, k))
            begin
                rd_d[P0_LVL_LSB +: LVL_W] = plev_q[2*k];
                rd_d[P0_MODE_BIT]         = pmode_q[2*k];
                rd_d[P0_POL_BIT]          = ppol_q[2*k];
                rd_d[P1_LVL_LSB +: LVL_W] = plev_q[2*k+1];
                rd_d[P1_MODE_BIT]         = pmode_q[2*k+1];
                rd_d[P1_POL_BIT]          = ppol_q[2*k+1];
            end
        end
        for (int j = 0; j < 8; j++)
        begin
            if (reg_addr == bank_addr(ISET_OFS, j / NIB))
                rd_d[(j % NIB)*NIB +: LVL_W] = ilv_q[j];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= '0;
        else if (reg_rd)
            rdata_q <= rd_d;
        else
            rdata_q <= '0;
    end

    // Outputs
    assign reg_rdata  = rdata_q;
    assign int_req    = req_q;
    assign int_level  = lvl_q;
    assign int_vector = vec_q;
    assign irq        = |pending; // Level, high while an enabled flag is set

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_ena_write_read;
        wr_ena ##1 (reg_rd && reg_addr == ENA_OFS && !wr_ena);
    endsequence

    a_flag_write_clear: assert property (
        wr_flag && reg_wdata[8] && !(ctl_q && internal_cause[0]) |=> !iflag_q[8])
        else $error("internal flag not cleared by a one");

    a_flag_cause_set: assert property (
        ctl_q && internal_cause[6] |=> iflag_q[15])
        else $error("internal cause did not set its flag");

    a_flag_gated_off: assert property (
        !ctl_q && !iflag_q[15] |=> !iflag_q[15])
        else $error("flag set while controller disabled");

    a_set_ignores_enable: assert property (
        ctl_q && !ena_q[9] && internal_cause[1] |=> iflag_q[9])
        else $error("disabled source flag not set");

    a_req_core_gate: assert property (
        int_req |-> $past(core_interrupt_enable)
                    && int_level > $past(core_interrupt_level))
        else $error("request raised against core state");

    a_req_source_ok: assert property (
        int_req |-> ($past(pending) & (16'h0001 << int_vector)) != 16'h0000)
        else $error("request from a source not pending and enabled");

    a_reserved_zero: assert property (
        reg_rd && (reg_addr == FLAG_OFS || reg_addr == ENA_OFS) |=> !reg_rdata[RSV_BIT])
        else $error("reserved bit read as one");

    a_enable_readback: assert property (
        s_ena_write_read |=> reg_rdata == ($past(reg_wdata, 2) & ENA_MASK))
        else $error("enable register did not read back");

    a_level_port_noclr: assert property (
        pmode_q[2] == MODE_LEVEL && wr_flag && reg_wdata[2] && port_flag[2]
        && g_port[2].u_chan.active && ctl_q |=> port_flag[2])
        else $error("level port flag cleared by software");
endmodule

// ===== test/ifeb_core_model.sv
`timescale 1ns/10ps
module ifeb_core_model
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    // Request from the controller
    input  wire logic       int_req,
    input  wire logic [2:0] int_level,
    input  wire logic [3:0] int_vector,
    // Software side of the core
    input  wire logic       ie_set,
    input  wire logic [2:0] il_set,
    // Status word toward the controller
    output logic            core_interrupt_enable,
    output logic [2:0]      core_interrupt_level,
    output logic [3:0]      taken_vec,
    output logic [7:0]      taken_cnt
);
    // Current level follows what the handler software programs
    assign core_interrupt_level = il_set;

    // Taking a request drops the enable bit, so nothing more is taken until software
    // sets it again; a slow handler is modelled by simply holding ie_set low
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            core_interrupt_enable <= 1'b0;
            taken_vec             <= 4'h0;
            taken_cnt             <= 8'h00;
        end
        else if (ie_set)
        begin
            core_interrupt_enable <= 1'b1;
        end
        else if (int_req && core_interrupt_enable && (int_level > core_interrupt_level))
        begin
            core_interrupt_enable <= 1'b0;
            taken_vec             <= int_vector;
            taken_cnt             <= taken_cnt + 8'h01;
        end
    end
endmodule

// ===== test/ifeb_top_tb.sv
`timescale 1ns/10ps
module ifeb_top_tb;
    import ifeb_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [6:0]  internal_cause = 7'h00;
    logic [7:0]  port_in = 8'hff;
    logic        cie;
    logic [2:0]  cil;
    logic        int_req;
    logic [2:0]  int_level;
    logic [3:0]  int_vector;
    logic        irq;
    logic        ie_set = 1'b0;
    logic [2:0]  il_set = 3'h0;
    logic [3:0]  taken_vec;
    logic [7:0]  taken_cnt;
    logic [15:0] rv;
    int          bad_count = 0;
    int          checks_done = 0;

    ifeb_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .internal_cause(internal_cause), .port_in(port_in), .core_interrupt_enable(cie),
        .core_interrupt_level(cil), .int_req(int_req), .int_level(int_level),
        .int_vector(int_vector), .irq(irq));
    ifeb_core_model i_core (.core_clk(core_clk), .reset_n(reset_n), .int_req(int_req),
        .int_level(int_level), .int_vector(int_vector), .ie_set(ie_set), .il_set(il_set),
        .core_interrupt_enable(cie), .core_interrupt_level(cil), .taken_vec(taken_vec),
        .taken_cnt(taken_cnt));

    // 40 MHz system clock
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Write then read with no idle cycle between the two strobes
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge core_clk);
        reg_rd    <= 1'b0;
        #1;
        q = reg_rdata;
    endtask

    task automatic rchk(input string what, input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd(a, d);
        chk(what, d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic pulse_cause(input int i);
        @(posedge core_clk);
        internal_cause[i] <= 1'b1;
        @(posedge core_clk);
        internal_cause[i] <= 1'b0;
        #1;
    endtask

    task automatic pin(input int i, input logic v);
        @(posedge core_clk);
        port_in[i] <= v;
        cyc(8);
    endtask

    task automatic t_reset_regs();
        rchk("flags", FLAG_OFS, 16'h0000);
        rchk("enables", ENA_OFS, 16'h0000);
        rchk("unmapped", 16'h4400, 16'h0000);
        wr_rd(ENA_OFS, 16'hffff, rv);
        chk("enables all", rv, 16'hdfff);
        wr(ENA_OFS, 16'h0000);
        rchk("enables none", ENA_OFS, 16'h0000);
        $display("test reset_regs done");
    endtask

    // Each cause lands on its own bit whatever the enables say; clears are write-1
    task automatic t_internal();
        pulse_cause(6);
        rchk("cause while off", FLAG_OFS, 16'h0000);
        wr(CTL_OFS, 16'h0001);
        for (int i = 0; i < 7; i++)
            pulse_cause(i);
        rchk("all causes", FLAG_OFS, 16'hdf00);
        chk("irq blocked", {15'h0000, irq}, 16'h0000);
        wr(FLAG_OFS, 16'h0000);
        rchk("write zero", FLAG_OFS, 16'hdf00);
        wr(ENA_OFS, 16'h8000);
        chk("irq on", {15'h0000, irq}, 16'h0001);
        wr(FLAG_OFS, 16'h2500);
        rchk("part clear", FLAG_OFS, 16'hda00);
        wr(CLR_OFS, 16'hffff);
        rchk("all clear", FLAG_OFS, 16'h0000);
        rchk("clear alias", CLR_OFS, 16'h0000);
        wr(ENA_OFS, 16'h0000);
        $display("test internal done");
    endtask

    task automatic t_request();
        wr(ISET_OFS, 16'h0003);
        wr(ENA_OFS, 16'h0100);
        il_set <= 3'h3;
        @(posedge core_clk);
        ie_set <= 1'b1;
        @(posedge core_clk);
        ie_set <= 1'b0;
        pulse_cause(0);
        cyc(4);
        chk("equal level", {15'h0000, int_req}, 16'h0000);
        il_set <= 3'h2;
        cyc(4);
        chk("taken", {8'h00, taken_cnt}, 16'h0001);
        chk("vector", {12'h000, taken_vec}, 16'h0008);
        chk("level out", {13'h0000, int_level}, 16'h0003);
        cyc(4);
        chk("no retake", {8'h00, taken_cnt}, 16'h0001);
        wr(FLAG_OFS, 16'h0100);
        @(posedge core_clk);
        ie_set <= 1'b1;
        @(posedge core_clk);
        ie_set <= 1'b0;
        cyc(4);
        chk("cleared", {8'h00, taken_cnt}, 16'h0001);
        wr(ENA_OFS, 16'h0000);
        $display("test request done");
    endtask

    // Port 0 rising pulse, port 1 falling pulse, port 2 active-low level
    task automatic t_ports();
        wr(PSET_OFS, 16'h0020);
        pin(0, 1'b0);
        pin(0, 1'b1);
        rchk("rise seen", FLAG_OFS, 16'h0001);
        wr(FLAG_OFS, 16'h0000);
        pin(0, 1'b0);
        pin(0, 1'b1);
        rchk("write zero port", FLAG_OFS, 16'h0001);
        wr(FLAG_OFS, 16'h0001);
        rchk("edge lost", FLAG_OFS, 16'h0000);
        pin(1, 1'b0);
        rchk("fall seen", FLAG_OFS, 16'h0002);
        wr(FLAG_OFS, 16'h0002);
        wr(PSET_OFS + REG_STEP, 16'h0010);
        rchk("level idle", FLAG_OFS, 16'h0000);
        pin(2, 1'b0);
        rchk("level active", FLAG_OFS, 16'h0004);
        wr(FLAG_OFS, 16'h0004);
        rchk("level no clear", FLAG_OFS, 16'h0004);
        pin(2, 1'b1);
        rchk("level gone", FLAG_OFS, 16'h0000);
        $display("test ports done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset_regs();
        t_internal();
        t_request();
        t_ports();
        stop_test();
    end

    // Watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        #(25 * 5000);
        bad_count++;
        stop_test();
    end
endmodule
